// ---- inc/ip_flow_verify_defs.vh ----
`ifndef IP_FLOW_VERIFY_DEFS_VH
`define IP_FLOW_VERIFY_DEFS_VH

`define ADDR_MODE 12'h000
`define ADDR_FLOWPTR 12'h004
`define ADDR_SIGPTR 12'h008
`define ADDR_STATUS 12'h00c
`define FLOW_REGION 3'h1
`define WORD_CTRL 4'h0
`define GRP_VALUE 2'h1
`define GRP_MASK 2'h2
`define GRP_PTPVAL 3'h6
`define GRP_PTPMASK 3'h7

`define CTRL_ENA 0
`define CTRL_SIDE_LO 1
`define CTRL_ACT_LO 4
`define CTRL_CHAN_LO 8

`define MODE_IPV4 2'h0
`define MODE_IPV6 2'h1
`define MODE_GEN32 2'h2
`define MODE_GEN128 2'h3

`define SIDE_SRC 2'h0
`define SIDE_DST 2'h1
`define SIDE_ANY 2'h2

`define OAM_NONE 2'h0
`define OAM_1DM 2'h1
`define OAM_DMM 2'h2
`define OAM_DMR 2'h3

`define SHORT_LEN 8'h04
`define LONG_LEN 8'h10

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define REG_RESET 32'h00000000

`endif

// ---- hdl/ip_flow_verify.v ----
`timescale 1ns/100ps
`include "ip_flow_verify_defs.vh"

module ip_flow_verify #(
	parameter NFLOW = 8,
	parameter NCHAN = 4,
	parameter CHW = 2,
	parameter SIG_PRESENT = 1,
	parameter [7:0] OPC_1DM = 8'h2d,
	parameter [7:0] OPC_DMM = 8'h2f,
	parameter [7:0] OPC_DMR = 8'h2e
) (
	input wire clk,
	input wire rst_n,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire hdrByteValid,
	input wire [7:0] hdrByte,
	input wire hdrFirst,
	input wire hdrLast,
	input wire [CHW-1:0] hdrChan,
	output reg flowValid,
	output reg flowHit,
	output reg [2:0] flowIdx,
	output reg [4:0] sigFieldPtr,
	input wire ptpValid,
	input wire ptpIsOam,
	input wire [63:0] ptpHead,
	input wire [CHW-1:0] ptpChan,
	output reg ptpOutValid,
	output reg ptpOutHit,
	output reg [2:0] ptpOutFlow,
	output reg [3:0] ptpOutAction,
	output reg [1:0] ptpOutOamType
);

// ----------------------------------------
// Storage
// ----------------------------------------
reg [31:0] ctrlMem [0:NFLOW-1];
reg [31:0] valMem [0:NFLOW*4-1];
reg [31:0] mskMem [0:NFLOW*4-1];
reg [31:0] ptpValMem [0:NFLOW*2-1];
reg [31:0] ptpMskMem [0:NFLOW*2-1];
reg [1:0] mode_q;
reg [4:0] flowPtr_q;
reg [11:0] awAddr_q;
reg [31:0] wData_q;
reg [3:0] wStrb_q;
reg [6:0] pos_q;
reg [127:0] srcF_q;
reg [127:0] dstF_q;
reg [CHW-1:0] chan_q;
reg eval_q;
reg [31:0] rdNext;
reg [NFLOW-1:0] hitVec;
reg [NFLOW-1:0] ptpVec;
reg [2:0] hitIdx;
reg [2:0] ptpIdx;
reg [1:0] oamType;
reg oamOk;
reg [127:0] cmpMsk;
reg [127:0] fv;
reg [127:0] fm;
reg [63:0] pm;
reg srcEq;
reg dstEq;
reg [1:0] side;
integer i;
// Each combinational block owns its loop index so one cannot wake the other
integer f;
integer p;

// ----------------------------------------
// Helpers
// ----------------------------------------
function regOk;
	input [11:0] a;
	begin
		if (a[11:9] == 3'h0)
			regOk = (a[8:4] == 5'h00);
		else if (a[11:9] == `FLOW_REGION)
			regOk = ({1'b0, a[8:6]} < NFLOW) && (a[5:2] == `WORD_CTRL || a[5:4] != 2'h0);
		else
			regOk = 1'b0;
	end
endfunction

function [31:0] mergeStrb;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] strb;
	integer b;
	begin
		mergeStrb = old;
		for (b = 0; b < 4; b = b + 1) begin
			if (strb[b])
				mergeStrb[b*8 +: 8] = nw[b*8 +: 8];
		end
	end
endfunction

// Short fields land in the low bytes of the shifter; move them to the top
function [127:0] alignKey;
	input [127:0] f;
	input shortLen;
	begin
		alignKey = shortLen ? {f[31:0], 96'h0} : f;
	end
endfunction

function fieldEq;
	input [127:0] k;
	input [127:0] v;
	input [127:0] m;
	begin
		fieldEq = (((k ^ v) & m) == 128'h0);
	end
endfunction

// ----------------------------------------
// Field capture
// ----------------------------------------
wire shortLen = (mode_q == `MODE_IPV4) || (mode_q == `MODE_GEN32);
wire [7:0] fLen = shortLen ? `SHORT_LEN : `LONG_LEN;
wire [7:0] posCur = hdrFirst ? 8'h00 : {1'b0, pos_q};
wire [7:0] srcBeg = {3'h0, flowPtr_q};
wire [7:0] srcEnd = srcBeg + fLen;
wire [7:0] dstEnd = srcEnd + fLen;
wire inSrc = (posCur >= srcBeg) && (posCur < srcEnd);
wire inDst = (posCur >= srcEnd) && (posCur < dstEnd);

always @(posedge clk) begin
	if (!rst_n) begin
		pos_q <= 7'h00;
		srcF_q <= 128'h0;
		dstF_q <= 128'h0;
		chan_q <= {CHW{1'b0}};
		eval_q <= 1'b0;
	end else begin
		eval_q <= hdrByteValid && hdrLast;
		if (hdrByteValid) begin
			if (hdrFirst)
				chan_q <= hdrChan;
			if (posCur[7] == 1'b0 && posCur[6:0] != 7'h7f)
				pos_q <= posCur[6:0] + 7'h01;
			if (inSrc)
				srcF_q <= {srcF_q[119:0], hdrByte};
			if (inDst)
				dstF_q <= {dstF_q[119:0], hdrByte};
		end
	end
end

// ----------------------------------------
// Flow compare
// ----------------------------------------
always @* begin
	hitVec = {NFLOW{1'b0}};
	hitIdx = 3'h0;
	fv = 128'h0;
	fm = 128'h0;
	cmpMsk = 128'h0;
	srcEq = 1'b0;
	dstEq = 1'b0;
	side = 2'h0;
	for (f = 0; f < NFLOW; f = f + 1) begin
		fv = {valMem[f*4], valMem[f*4+1], valMem[f*4+2], valMem[f*4+3]};
		fm = {mskMem[f*4], mskMem[f*4+1], mskMem[f*4+2], mskMem[f*4+3]};
		cmpMsk = shortLen ? {fm[127:96], 96'h0} : fm;
		srcEq = fieldEq(alignKey(srcF_q, shortLen), fv, cmpMsk);
		dstEq = fieldEq(alignKey(dstF_q, shortLen), fv, cmpMsk);
		side = ctrlMem[f][`CTRL_SIDE_LO +: 2];
		if (mode_q == `MODE_IPV4 || mode_q == `MODE_IPV6) begin
			case (side)
				`SIDE_SRC: hitVec[f] = srcEq;
				`SIDE_DST: hitVec[f] = dstEq;
				`SIDE_ANY: hitVec[f] = srcEq || dstEq;
				default: hitVec[f] = 1'b0;
			endcase
		end else begin
			hitVec[f] = srcEq;
		end
		// Disabled flows and unselected channels never match
		if (!ctrlMem[f][`CTRL_ENA])
			hitVec[f] = 1'b0;
		if (!ctrlMem[f][`CTRL_CHAN_LO + chan_q])
			hitVec[f] = 1'b0;
	end
	for (f = NFLOW - 1; f >= 0; f = f - 1) begin
		if (hitVec[f])
			hitIdx = f[2:0];
	end
end

// ----------------------------------------
// PTP / OAM final stage
// ----------------------------------------
always @* begin
	ptpVec = {NFLOW{1'b0}};
	ptpIdx = 3'h0;
	pm = 64'h0;
	oamType = `OAM_NONE;
	case (ptpHead[55:48])
		OPC_1DM: oamType = `OAM_1DM;
		OPC_DMM: oamType = `OAM_DMM;
		OPC_DMR: oamType = `OAM_DMR;
		default: oamType = `OAM_NONE;
	endcase
	oamOk = !ptpIsOam || (oamType != `OAM_NONE);
	for (p = 0; p < NFLOW; p = p + 1) begin
		pm = {ptpMskMem[p*2], ptpMskMem[p*2+1]};
		// OAM looks at four header bytes, PTP at eight
		if (ptpIsOam)
			pm = {pm[63:32], 32'h0};
		ptpVec[p] = ((ptpHead ^ {ptpValMem[p*2], ptpValMem[p*2+1]}) & pm) == 64'h0;
		if (!ctrlMem[p][`CTRL_ENA] || !ctrlMem[p][`CTRL_CHAN_LO + ptpChan] || !oamOk)
			ptpVec[p] = 1'b0;
	end
	for (p = NFLOW - 1; p >= 0; p = p - 1) begin
		if (ptpVec[p])
			ptpIdx = p[2:0];
	end
end

// Flow result two cycles after the last header byte, PTP result one cycle after ptpValid; nothing follows this stage
always @(posedge clk) begin
	if (!rst_n) begin
		flowValid <= 1'b0;
		flowHit <= 1'b0;
		flowIdx <= 3'h0;
		ptpOutValid <= 1'b0;
		ptpOutHit <= 1'b0;
		ptpOutFlow <= 3'h0;
		ptpOutAction <= 4'h0;
		ptpOutOamType <= `OAM_NONE;
	end else begin
		flowValid <= eval_q;
		if (eval_q) begin
			flowHit <= |hitVec;
			flowIdx <= hitIdx;
		end
		ptpOutValid <= ptpValid;
		if (ptpValid) begin
			ptpOutHit <= |ptpVec;
			ptpOutFlow <= ptpIdx;
			ptpOutAction <= (|ptpVec) ? ctrlMem[ptpIdx][`CTRL_ACT_LO +: 4] : 4'h0;
			ptpOutOamType <= ptpIsOam ? oamType : `OAM_NONE;
		end
	end
end

// ----------------------------------------
// Register read mux
// ----------------------------------------
always @* begin
	rdNext = `REG_RESET;
	if (regOk(s_axi_araddr)) begin
		if (s_axi_araddr[11:9] == 3'h0) begin
			case (s_axi_araddr)
				`ADDR_MODE: rdNext = {30'h0, mode_q};
				`ADDR_FLOWPTR: rdNext = {27'h0, flowPtr_q};
				`ADDR_SIGPTR: rdNext = {27'h0, sigFieldPtr};
				`ADDR_STATUS: rdNext = {20'h0, ptpOutFlow, ptpOutHit, 4'h0, flowIdx, flowHit};
				default: rdNext = `REG_RESET;
			endcase
		end else if (s_axi_araddr[5:2] == `WORD_CTRL) begin
			rdNext = ctrlMem[s_axi_araddr[8:6]];
		end else if (s_axi_araddr[5:4] == `GRP_VALUE) begin
			rdNext = valMem[{s_axi_araddr[8:6], s_axi_araddr[3:2]}];
		end else if (s_axi_araddr[5:4] == `GRP_MASK) begin
			rdNext = mskMem[{s_axi_araddr[8:6], s_axi_araddr[3:2]}];
		end else if (s_axi_araddr[5:3] == `GRP_PTPVAL) begin
			rdNext = ptpValMem[{s_axi_araddr[8:6], s_axi_araddr[2]}];
		end else begin
			rdNext = ptpMskMem[{s_axi_araddr[8:6], s_axi_araddr[2]}];
		end
	end
end

// ----------------------------------------
// AXI4-Lite slave
// ----------------------------------------
wire awHeld = !s_axi_awready;
wire wHeld = !s_axi_wready;
wire doWrite = awHeld && wHeld && !s_axi_bvalid;

always @(posedge clk) begin
	if (!rst_n) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= `REG_RESET;
		s_axi_rresp <= `RESP_OKAY;
		awAddr_q <= 12'h000;
		wData_q <= `REG_RESET;
		wStrb_q <= 4'h0;
		mode_q <= `MODE_IPV4;
		flowPtr_q <= 5'h00;
		sigFieldPtr <= 5'h00;
		for (i = 0; i < NFLOW; i = i + 1)
			ctrlMem[i] <= `REG_RESET;
		for (i = 0; i < NFLOW * 4; i = i + 1) begin
			valMem[i] <= `REG_RESET;
			mskMem[i] <= `REG_RESET;
		end
		for (i = 0; i < NFLOW * 2; i = i + 1) begin
			ptpValMem[i] <= `REG_RESET;
			ptpMskMem[i] <= `REG_RESET;
		end
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			awAddr_q <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= regOk(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
			if (regOk(awAddr_q)) begin
				if (awAddr_q[11:9] == 3'h0) begin
					case (awAddr_q)
						`ADDR_MODE: if (wStrb_q[0]) mode_q <= wData_q[1:0];
						`ADDR_FLOWPTR: if (wStrb_q[0]) flowPtr_q <= wData_q[4:0];
						// Pointer is writable only where a signature FIFO is present (SIG_PRESENT)
						`ADDR_SIGPTR: if (SIG_PRESENT != 0) sigFieldPtr <= wData_q[4:0] & {5{wStrb_q[0]}} | sigFieldPtr & {5{!wStrb_q[0]}};
						default: mode_q <= mode_q;
					endcase
				end else if (awAddr_q[5:2] == `WORD_CTRL) begin
					ctrlMem[awAddr_q[8:6]] <= mergeStrb(ctrlMem[awAddr_q[8:6]], wData_q, wStrb_q);
				end else if (awAddr_q[5:4] == `GRP_VALUE) begin
					valMem[{awAddr_q[8:6], awAddr_q[3:2]}] <= mergeStrb(valMem[{awAddr_q[8:6], awAddr_q[3:2]}], wData_q, wStrb_q);
				end else if (awAddr_q[5:4] == `GRP_MASK) begin
					mskMem[{awAddr_q[8:6], awAddr_q[3:2]}] <= mergeStrb(mskMem[{awAddr_q[8:6], awAddr_q[3:2]}], wData_q, wStrb_q);
				end else if (awAddr_q[5:3] == `GRP_PTPVAL) begin
					ptpValMem[{awAddr_q[8:6], awAddr_q[2]}] <= mergeStrb(ptpValMem[{awAddr_q[8:6], awAddr_q[2]}], wData_q, wStrb_q);
				end else begin
					ptpMskMem[{awAddr_q[8:6], awAddr_q[2]}] <= mergeStrb(ptpMskMem[{awAddr_q[8:6], awAddr_q[2]}], wData_q, wStrb_q);
				end
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdNext;
			s_axi_rresp <= regOk(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule // ip_flow_verify

// ---- dv/ip_flow_verify_assertions.sv ----
`timescale 1ns/100ps
module ip_flow_verify_assertions (
	input wire clk,
	input wire rst_n,
	input wire hdrByteValid,
	input wire hdrLast,
	input wire flowValid,
	input wire flowHit,
	input wire [2:0] flowIdx,
	input wire ptpValid,
	input wire ptpIsOam,
	input wire ptpOutValid,
	input wire ptpOutHit,
	input wire [3:0] ptpOutAction,
	input wire [1:0] ptpOutOamType
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_flow_answer: assert property (hdrByteValid && hdrLast |-> ##2 flowValid)
		else $error("flow result missing");
	a_flow_cause: assert property (flowValid |-> $past(hdrByteValid, 2) && $past(hdrLast, 2))
		else $error("flow result without last byte");
	a_result_held: assert property (!flowValid |-> $stable({flowHit, flowIdx}))
		else $error("flow result moved");
	a_idx_nohit: assert property (flowValid && !flowHit |-> flowIdx == 3'h0)
		else $error("index without hit");
	a_ptp_answer: assert property (ptpValid |=> ptpOutValid)
		else $error("ptp result missing");
	a_ptp_cause: assert property (ptpOutValid |-> $past(ptpValid))
		else $error("ptp result without request");
	a_action_nohit: assert property (ptpOutValid && !ptpOutHit |-> ptpOutAction == 4'h0)
		else $error("action without hit");
	a_oam_typed: assert property (ptpOutValid && ptpOutHit && $past(ptpIsOam) |-> ptpOutOamType != 2'h0)
		else $error("oam hit untyped");
endmodule // ip_flow_verify_assertions

bind ip_flow_verify ip_flow_verify_assertions u_chk (.clk, .rst_n, .hdrByteValid, .hdrLast, .flowValid,
	.flowHit, .flowIdx, .ptpValid, .ptpIsOam, .ptpOutValid, .ptpOutHit, .ptpOutAction, .ptpOutOamType);

// ---- dv/hdr_source.sv ----
`timescale 1ns/100ps
module hdr_source (
	input wire clk,
	input wire srcStart,
	input wire [5:0] srcLen,
	input wire srcGap,
	output reg hdrByteValid = 1'h0,
	output reg [7:0] hdrByte = 8'h00,
	output reg hdrFirst = 1'h0,
	output reg hdrLast = 1'h0
);
	reg [7:0] mem [0:63];
	reg [5:0] pos = 6'h00;
	reg busy = 1'h0;
	reg phase = 1'h0;
	wire step = busy && !(srcGap && phase);
	always @(posedge clk) begin
		phase <= ~phase;
		hdrByteValid <= step;
		hdrFirst <= step && pos == 6'h00;
		hdrLast <= step && pos == srcLen - 6'h01;
		// Idle byte lane toggles so a stale value can never match
		hdrByte <= step ? mem[pos] : ~hdrByte;
		if (step)
			pos <= pos + 6'h01;
		if (step && pos == srcLen - 6'h01)
			busy <= 1'h0;
		if (srcStart) begin
			busy <= 1'h1;
			pos <= 6'h00;
		end
	end
endmodule // hdr_source

// ---- dv/ip_flow_verify_test.sv ----
`timescale 1ns/100ps
`include "ip_flow_verify_defs.vh"
module ip_flow_verify_test;
	reg clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
	reg s_axi_rready = 1, ptpValid = 0, ptpIsOam = 0, srcStart = 0, srcGap = 0;
	reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0, rdWord;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg [1:0] hdrChan = 1, ptpChan = 1, lastResp;
	reg [63:0] ptpHead = 0;
	reg [5:0] srcLen = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flowValid, flowHit;
	wire hdrByteValid, hdrFirst, hdrLast, ptpOutValid, ptpOutHit;
	wire [1:0] s_axi_bresp, s_axi_rresp, ptpOutOamType;
	wire [31:0] s_axi_rdata;
	wire [2:0] flowIdx, ptpOutFlow;
	wire [4:0] sigFieldPtr;
	wire [3:0] ptpOutAction;
	wire [7:0] hdrByte;
	int failures = 0, compares = 0;
	ip_flow_verify u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hdrByteValid, .hdrByte,
		.hdrFirst, .hdrLast, .hdrChan, .flowValid, .flowHit, .flowIdx, .sigFieldPtr, .ptpValid, .ptpIsOam,
		.ptpHead, .ptpChan, .ptpOutValid, .ptpOutHit, .ptpOutFlow, .ptpOutAction, .ptpOutOamType);
	hdr_source u_src (.clk, .srcStart, .srcLen, .srcGap, .hdrByteValid, .hdrByte, .hdrFirst, .hdrLast);
	always #2 clk = ~clk;
	// ----------------
	// Bus and stream helpers
	// ----------------
	task chk(input [31:0] got, input [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 50);
		lastResp = s_axi_bresp;
		if (n == 50) chk(0, 1);
	endtask
	task rd(input [11:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 50);
		rdWord = s_axi_rdata;
		lastResp = s_axi_rresp;
		if (n == 50) chk(0, 1);
	endtask
	// Low value and mask words stay all ones so any use of them shows
	task setflow(input [11:0] b, input [31:0] ctrl, input [31:0] v, input [31:0] m);
		wr(b, ctrl);
		wr(b + 12'h010, v);
		wr(b + 12'h020, m);
		for (int i = 1; i < 4; i++) begin
			wr(b + 12'h010 + 12'(4 * i), 32'hffffffff);
			wr(b + 12'h020 + 12'(4 * i), 32'hffffffff);
		end
	endtask
	task hdr(input gap, input eHit, input [2:0] eIdx);
		int n;
		n = 0;
		srcLen <= 6'h24;
		srcGap <= gap;
		srcStart <= 1'h1;
		@(posedge clk);
		srcStart <= 1'h0;
		while (!flowValid && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(flowValid, 1);
		chk(flowHit, eHit);
		chk(flowIdx, eIdx);
		@(posedge clk);
	endtask
	task ptp(input oam, input [63:0] h, input eHit, input [2:0] eFlow, input [1:0] eType);
		ptpIsOam <= oam;
		ptpHead <= h;
		ptpValid <= 1'h1;
		@(posedge clk);
		ptpValid <= 1'h0;
		ptpHead <= ~h;
		@(posedge clk);
		chk(ptpOutValid, 1);
		chk(ptpOutHit, eHit);
		chk(ptpOutAction, eHit ? 5 : 0);
		chk(ptpOutFlow, eFlow);
		chk(ptpOutOamType, eType);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task t_regs;
		rd(`ADDR_MODE);
		chk(rdWord, 0);
		wr(`ADDR_MODE, 32'h3);
		rd(`ADDR_MODE);
		chk(rdWord, 3);
		wr(`ADDR_SIGPTR, 32'hff);
		rd(`ADDR_SIGPTR);
		chk(rdWord, 32'h1f);
		chk(sigFieldPtr, 5'h1f);
		wr(12'h204, 32'h1);
		chk(lastResp, `RESP_SLVERR);
		rd(12'h204);
		chk(lastResp, `RESP_SLVERR);
	endtask
	task t_ptp;
		ptp(0, 64'h2100000000000077, 0, 0, 0);
		wr(12'h200, 32'h251);
		wr(12'h230, 32'h21000000);
		wr(12'h234, 32'h77);
		wr(12'h238, 32'hff000000);
		wr(12'h23c, 32'hff);
		rd(12'h234);
		chk(rdWord, 32'h77);
		chk(lastResp, `RESP_OKAY);
		ptp(0, 64'h2100000000000077, 1, 0, 0);
		ptp(0, 64'h2100000000000000, 0, 0, 0);
		ptp(1, {8'h21, u_dut.OPC_1DM, 48'h0}, 1, 0, 1);
		ptp(1, {8'h21, u_dut.OPC_DMM, 48'h0}, 1, 0, 2);
		ptp(1, {8'h21, u_dut.OPC_DMR, 48'h0}, 1, 0, 3);
		ptp(1, 64'h2100000000000077, 0, 0, 0);
		ptpChan <= 2'h0;
		ptp(0, 64'h2100000000000077, 0, 0, 0);
		ptpChan <= 2'h1;
		// Flow 3 matches too: flow 0 wins, then flow 3 alone once flow 0 is off
		wr(12'h2c0, 32'h251);
		wr(12'h2f0, 32'h21000000);
		wr(12'h2f8, 32'hff000000);
		ptp(0, 64'h2100000000000077, 1, 0, 0);
		wr(12'h200, 32'h250);
		ptp(0, 64'h2100000000000077, 1, 3, 0);
		// Flow 3 has zero IP mask and would match every header
		wr(12'h2c0, 32'h000);
	endtask
	task t_ipv4;
		wr(`ADDR_MODE, `MODE_IPV4);
		wr(`ADDR_FLOWPTR, 32'hc);
		for (int s = 0; s < 3; s++) begin
			setflow(12'h200, 32'h201 | (s << 1), 32'h10111213, 32'hffffffff);
			hdr(s == 2, s > 0, 0);
		end
		wr(12'h200, 32'h204);
		hdr(0, 0, 0);
		wr(12'h200, 32'h005);
		hdr(0, 0, 0);
		setflow(12'h280, 32'h205, 32'h0c0d0e0f, 32'hffffffff);
		setflow(12'h340, 32'h205, 32'h0c0d0e0f, 32'hffffffff);
		hdr(0, 1, 2);
		rd(`ADDR_STATUS);
		chk(rdWord, 32'h705);
	endtask
	task t_generic;
		wr(`ADDR_MODE, `MODE_GEN32);
		wr(`ADDR_FLOWPTR, 32'h4);
		setflow(12'h200, 32'h203, 32'h0405ffff, 32'hffff0000);
		hdr(0, 1, 0);
		wr(`ADDR_MODE, `MODE_GEN128);
		hdr(0, 0, 0);
		// Full 128-bit destination match in IPv6, then the source side misses
		wr(`ADDR_MODE, `MODE_IPV6);
		setflow(12'h200, 32'h203, 32'h14151617, 32'hffffffff);
		wr(12'h214, 32'h18191a1b);
		wr(12'h218, 32'h1c1d1e1f);
		wr(12'h21c, 32'h20212223);
		hdr(0, 1, 0);
		wr(12'h200, 32'h201);
		hdr(0, 0, 0);
	endtask
	task final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 64; i++) u_src.mem[i] = 8'(i);
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_regs;
		t_ptp;
		t_ipv4;
		t_generic;
		final_report;
	end
	initial begin
		#40000;
		failures++;
		final_report;
	end
endmodule // ip_flow_verify_test
